// [src/timer1_map.svh]
`ifndef TIMER1_MAP_SVH
`define TIMER1_MAP_SVH

// i/o addresses of the registers
`define T1_ADDR_IRQ_FLAGS   8'h16
`define T1_ADDR_GEN_CTRL    8'h23
`define T1_ADDR_IRQ_MASK    8'h6f
`define T1_ADDR_CAPT_LOW    8'h86
`define T1_ADDR_CAPT_HIGH   8'h87

// reset values
`define T1_RST_IRQ_FLAGS    8'h00
`define T1_RST_GEN_CTRL     8'h00
`define T1_RST_IRQ_MASK     8'h00
`define T1_RST_CAPT         16'h0000
`define T1_RST_LATCH        8'h00

// bit positions shared by mask and flag registers
`define T1_BIT_OVERFLOW     0
`define T1_BIT_COMPARE_A    1
`define T1_BIT_COMPARE_B    2
`define T1_BIT_CAPTURE      5
`define T1_IRQ_IMPL_MASK    8'h27

// general timer control bit positions
`define T1_BIT_SHARED_PSR   0
`define T1_BIT_ASYNC_PSR    1
`define T1_BIT_SYNC_HALT    7
`define T1_GEN_IMPL_MASK    8'h83

// waveform mode codes that matter here
`define T1_WGM_NORMAL       4'h0
`define T1_WGM_CTC_CMP_A    4'h4
`define T1_WGM_PC_CAPT      4'h8
`define T1_WGM_PFC_CAPT     4'ha
`define T1_WGM_CTC_CAPT     4'hc
`define T1_WGM_FAST_CAPT    4'he

`endif

// [src/timer1_pkg.sv]
package timer1_pkg;

  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef logic [3:0]  wgm_t;

  // which counter event marks an overflow in a given waveform mode
  typedef enum logic [1:0] {
    ovf_at_max    = 2'h0,
    ovf_at_top    = 2'h1,
    ovf_at_bottom = 2'h2
  } ovf_src_t;

endpackage : timer1_pkg

// [src/capture_edge_detect.sv]
`timescale 1ns/1ps

// picks the selected edge of the capture pin as a one-cycle pulse
module capture_edge_detect (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic nrst,
  // pin side
  input  wire logic pin_level,
  input  wire logic rising_sel,
  input  wire logic pin_enable,
  // event
  output logic      edge_pulse
);

  logic pin_prev;

  // previous level; pin is already synchronous to ref_clk
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_prev <= 1'b0;
    end else begin
      pin_prev <= pin_level;
    end
  end

  // zero picks the falling edge, one the rising edge
  wire rise_seen = pin_level & ~pin_prev;
  wire fall_seen = ~pin_level & pin_prev;
  assign edge_pulse = pin_enable & (rising_sel ? rise_seen : fall_seen);

endmodule : capture_edge_detect

// [src/timer1_capture_irq_prescaler.sv]
`timescale 1ns/1ps
`include "timer1_map.svh"

module timer1_capture_irq_prescaler (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              nrst,
  // internal i/o bus
  input  wire logic [7:0]        io_addr,
  input  wire logic              io_we,
  input  wire logic              io_re,
  input  wire timer1_pkg::byte_t io_wdata,
  output timer1_pkg::byte_t      io_rdata,
  // shared high-byte latch, for the other 16-bit registers
  input  wire logic              ext_latch_we,
  input  wire timer1_pkg::byte_t ext_latch_data,
  output timer1_pkg::byte_t      high_byte_latch,
  // counter unit
  input  wire logic              timer_tick,
  input  wire timer1_pkg::word_t counter_value,
  input  wire timer1_pkg::word_t compare_a_value,
  input  wire timer1_pkg::word_t compare_b_value,
  input  wire timer1_pkg::wgm_t  waveform_mode_field,
  input  wire logic              counter_at_max,
  input  wire logic              counter_at_top,
  input  wire logic              counter_at_bottom,
  input  wire logic              force_compare_a_strobe,
  input  wire logic              force_compare_b_strobe,
  output logic                   capture_is_top,
  output timer1_pkg::word_t      capture_value_reg,
  // capture pin
  input  wire logic              capture_input_pin,
  input  wire logic              capture_edge_select,
  // interrupt controller
  input  wire logic              global_irq_enable,
  input  wire logic              capture_vector_ack,
  input  wire logic              compare_b_vector_ack,
  input  wire logic              compare_a_vector_ack,
  input  wire logic              overflow_vector_ack,
  output logic                   capture_irq,
  output logic                   compare_b_irq,
  output logic                   compare_a_irq,
  output logic                   overflow_irq,
  // prescaler control
  output logic                   sync_halt_mode,
  output logic                   shared_prescaler_reset,
  output logic                   async_prescaler_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  timer1_pkg::byte_t  timer1_irq_mask;
  timer1_pkg::byte_t  timer1_irq_flags;
  timer1_pkg::byte_t  general_timer_control;
  timer1_pkg::ovf_src_t ovf_src;

  logic [3:0] flag_q;
  logic [3:0] flag_set;
  logic [3:0] flag_w1c;
  logic [3:0] flag_ack;
  logic [3:0] flag_en;
  logic [3:0] irq_req;

  logic match_a_armed;
  logic match_b_armed;
  logic pin_capture;
  logic capture_event;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  // full 8-bit compare; the i/o space has no mirrors, so an address
  // that matches none of these reads as zero and ignores writes
  wire sel_flags = (io_addr == `T1_ADDR_IRQ_FLAGS);
  wire sel_gen   = (io_addr == `T1_ADDR_GEN_CTRL);
  wire sel_mask  = (io_addr == `T1_ADDR_IRQ_MASK);
  wire sel_low   = (io_addr == `T1_ADDR_CAPT_LOW);
  wire sel_high  = (io_addr == `T1_ADDR_CAPT_HIGH);

  wire we_flags = io_we & sel_flags;
  wire we_gen   = io_we & sel_gen;
  wire we_mask  = io_we & sel_mask;
  wire we_low   = io_we & sel_low;
  wire we_high  = io_we & sel_high;
  wire re_low   = io_re & sel_low;

  ////////////////////////////////////////////////////////////////////////////
  // waveform mode decode

  // the four modes in which the capture register defines TOP
  wire wgm_capt_top = (waveform_mode_field == `T1_WGM_PC_CAPT)
                    | (waveform_mode_field == `T1_WGM_PFC_CAPT)
                    | (waveform_mode_field == `T1_WGM_CTC_CAPT)
                    | (waveform_mode_field == `T1_WGM_FAST_CAPT);
  assign capture_is_top = wgm_capt_top;

  wire wgm_non_pwm = (waveform_mode_field == `T1_WGM_NORMAL)
                   | (waveform_mode_field == `T1_WGM_CTC_CMP_A)
                   | (waveform_mode_field == `T1_WGM_CTC_CAPT);

  // fast pwm decode takes modes 5,6,7,13,14,15: bit 2 set with a nonzero low pair
  wire wgm_fast = waveform_mode_field[2] & (waveform_mode_field[1:0] != 2'h0);

  // normal and ctc count past max; fast pwm flags at top, others at bottom
  assign ovf_src = wgm_non_pwm ? timer1_pkg::ovf_at_max
                 : wgm_fast    ? timer1_pkg::ovf_at_top
                 :               timer1_pkg::ovf_at_bottom;

  ////////////////////////////////////////////////////////////////////////////
  // capture pin

  // pin is cut off while the capture register is TOP
  capture_edge_detect u_edge (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .pin_level  (capture_input_pin),
    .rising_sel (capture_edge_select),
    .pin_enable (~wgm_capt_top),
    .edge_pulse (pin_capture)
  );

  // the capture event keeps its own name so a noise filter or a second
  // trigger source can be merged here without touching the flag logic
  assign capture_event = pin_capture;

  ////////////////////////////////////////////////////////////////////////////
  // capture register and shared high-byte latch

  // a capture outranks a cpu low-byte write landing in the same cycle,
  // since the counter snapshot cannot be repeated later
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      capture_value_reg <= `T1_RST_CAPT;
    end else if (capture_event) begin
      capture_value_reg <= counter_value;
    end else if (we_low) begin
      capture_value_reg <= {high_byte_latch, io_wdata};
    end
  end

  // latch: filled by a high-byte write or a low-byte read of any 16-bit reg
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      high_byte_latch <= `T1_RST_LATCH;
    end else if (we_high) begin
      high_byte_latch <= io_wdata;
    end else if (re_low) begin
      high_byte_latch <= capture_value_reg[15:8];
    end else if (ext_latch_we) begin
      high_byte_latch <= ext_latch_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare match detection

  // the match is seen on one tick and flagged on the next one
  wire match_a = timer_tick & (counter_value == compare_a_value);
  wire match_b = timer_tick & (counter_value == compare_b_value);

  // the armed bits only move on a tick, so a match that the counter unit
  // holds for many ref_clk cycles between ticks still flags only once
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      match_a_armed <= 1'b0;
      match_b_armed <= 1'b0;
    end else if (timer_tick) begin
      match_a_armed <= match_a;
      match_b_armed <= match_b;
    end
  end

  // forced compare strobes act on the waveform unit only; they are
  // deliberately not part of any flag set term here
  wire force_seen = force_compare_a_strobe | force_compare_b_strobe;

  ////////////////////////////////////////////////////////////////////////////
  // flag set, clear and request terms

  // a counter unit that reports max, top and bottom in one cycle is
  // harmless: only the source picked by the mode reaches the flag
  // overflow point selected by the waveform mode
  wire ovf_event = (ovf_src == timer1_pkg::ovf_at_max)    ? counter_at_max
                 : (ovf_src == timer1_pkg::ovf_at_top)    ? counter_at_top
                 :                                          counter_at_bottom;

  // capture flag source swaps to TOP when the capture register is TOP
  wire capt_flag_event = wgm_capt_top ? counter_at_top : capture_event;

  // index 0 overflow, 1 compare a, 2 compare b, 3 capture
  assign flag_set[0] = ovf_event;
  assign flag_set[1] = timer_tick & match_a_armed;
  assign flag_set[2] = timer_tick & match_b_armed;
  assign flag_set[3] = capt_flag_event;

  assign flag_w1c[0] = we_flags & io_wdata[`T1_BIT_OVERFLOW];
  assign flag_w1c[1] = we_flags & io_wdata[`T1_BIT_COMPARE_A];
  assign flag_w1c[2] = we_flags & io_wdata[`T1_BIT_COMPARE_B];
  assign flag_w1c[3] = we_flags & io_wdata[`T1_BIT_CAPTURE];

  assign flag_ack[0] = overflow_vector_ack;
  assign flag_ack[1] = compare_a_vector_ack;
  assign flag_ack[2] = compare_b_vector_ack;
  assign flag_ack[3] = capture_vector_ack;

  assign flag_en[0] = timer1_irq_mask[`T1_BIT_OVERFLOW];
  assign flag_en[1] = timer1_irq_mask[`T1_BIT_COMPARE_A];
  assign flag_en[2] = timer1_irq_mask[`T1_BIT_COMPARE_B];
  assign flag_en[3] = timer1_irq_mask[`T1_BIT_CAPTURE];

  ////////////////////////////////////////////////////////////////////////////
  // per-flag logic

  // a set arriving with a clear wins, so no event is ever dropped
  // a vector ack that loses to a new set leaves the flag pending, which
  // only re-enters the handler; losing an event would be worse
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_flag
      always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
          flag_q[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flag_q[gi] <= 1'b1;
        end else if (flag_w1c[gi] | flag_ack[gi]) begin
          flag_q[gi] <= 1'b0;
        end
      end

      // request is a plain and of enable, global flag and pending flag
      assign irq_req[gi] = flag_en[gi] & global_irq_enable & flag_q[gi];
    end
  endgenerate

  assign overflow_irq  = irq_req[0];
  assign compare_a_irq = irq_req[1];
  assign compare_b_irq = irq_req[2];
  assign capture_irq   = irq_req[3];

  // flag register image; unused positions tie to zero
  always_comb begin
    timer1_irq_flags = `T1_RST_IRQ_FLAGS;
    timer1_irq_flags[`T1_BIT_OVERFLOW]  = flag_q[0];
    timer1_irq_flags[`T1_BIT_COMPARE_A] = flag_q[1];
    timer1_irq_flags[`T1_BIT_COMPARE_B] = flag_q[2];
    timer1_irq_flags[`T1_BIT_CAPTURE]   = flag_q[3];
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask register

  // only implemented bits are stored, so the rest stay zero on read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      timer1_irq_mask <= `T1_RST_IRQ_MASK;
    end else if (we_mask) begin
      timer1_irq_mask <= io_wdata & `T1_IRQ_IMPL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // general timer control

  // write data fields of the control register; the async reset sits at
  // bit 1, and software that has no asynchronous timer leaves it zero
  wire wr_sync  = io_wdata[`T1_BIT_SYNC_HALT];
  wire wr_shared = io_wdata[`T1_BIT_SHARED_PSR];
  wire wr_async = io_wdata[`T1_BIT_ASYNC_PSR];

  // reset bits hold while sync mode is on and drop on the next cycle
  // otherwise; a written one therefore always gives at least one
  // cycle of prescaler reset even outside sync mode
  wire next_shared = we_gen ? wr_shared : (shared_prescaler_reset & sync_halt_mode);
  wire next_async  = we_gen ? wr_async  : (async_prescaler_reset & sync_halt_mode);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sync_halt_mode         <= 1'b0;
      shared_prescaler_reset <= 1'b0;
      async_prescaler_reset  <= 1'b0;
    end else begin
      if (we_gen) begin
        sync_halt_mode <= wr_sync;
      end
      shared_prescaler_reset <= next_shared;
      async_prescaler_reset  <= next_async;
    end
  end

  // writing sync mode to zero lets the bits fall together next cycle,
  // so every halted timer resumes on the same edge
  always_comb begin
    general_timer_control = `T1_RST_GEN_CTRL;
    general_timer_control[`T1_BIT_SYNC_HALT]  = sync_halt_mode;
    general_timer_control[`T1_BIT_SHARED_PSR] = shared_prescaler_reset;
    general_timer_control[`T1_BIT_ASYNC_PSR]  = async_prescaler_reset;
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  // high-byte read returns the latch, not the live register, so the
  // pair read low-then-high stays coherent across a capture
  wire [7:0] rd_mux = sel_flags ? timer1_irq_flags
                    : sel_gen   ? general_timer_control
                    : sel_mask  ? timer1_irq_mask
                    : sel_low   ? capture_value_reg[7:0]
                    : sel_high  ? high_byte_latch
                    :             8'h00;

  // read data held until the next read; unmapped addresses give zero
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (io_re) begin
      io_rdata <= rd_mux;
    end
  end

  // a forced compare has no effect on this block; the wire is kept
  // only so the strobe visibly terminates here
  wire unused_force = force_seen & 1'b0;

endmodule : timer1_capture_irq_prescaler

// [verif/timer1_chk.sv]
`timescale 1ns/1ps
module timer1_chk (
  // clock and reset
  input wire logic              ref_clk,
  input wire logic              nrst,
  // register bus
  input wire logic [7:0]        io_addr,
  input wire logic              io_we,
  input wire logic              io_re,
  input wire timer1_pkg::byte_t io_wdata,
  input wire timer1_pkg::byte_t io_rdata,
  input wire timer1_pkg::byte_t high_byte_latch,
  // capture path
  input wire timer1_pkg::word_t counter_value,
  input wire timer1_pkg::word_t capture_value_reg,
  input wire timer1_pkg::wgm_t  waveform_mode_field,
  input wire logic              capture_is_top,
  input wire logic              capture_input_pin,
  input wire logic              capture_edge_select,
  // interrupts and prescaler
  input wire logic              global_irq_enable,
  input wire logic              capture_irq,
  input wire logic              compare_b_irq,
  input wire logic              compare_a_irq,
  input wire logic              overflow_irq,
  input wire logic              sync_halt_mode,
  input wire logic              shared_prescaler_reset,
  input wire logic              async_prescaler_reset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic       pin_q;
  logic [1:0] up;

  // pin history; up masks the first edges after reset where the history is stale
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b0;
      up    <= 2'h0;
    end else begin
      pin_q <= capture_input_pin;
      up    <= (up == 2'h3) ? up : up + 2'h1;
    end
  end

  // bus decodes and the selected pin edge
  wire w23 = io_we && io_addr == 8'h23;
  wire w86 = io_we && io_addr == 8'h86;
  wire hit = up == 2'h3 && (capture_edge_select ? capture_input_pin && !pin_q : !capture_input_pin && pin_q);

  ////////////////////////////////////////////////////////////////////////////////
  property p_capture; hit && !capture_is_top |=> capture_value_reg == $past(counter_value); endproperty
  a_capture: assert property (p_capture) else $error("capture value not loaded");
  property p_top_hold; hit && capture_is_top && !w86 |=> $stable(capture_value_reg); endproperty
  a_top_hold: assert property (p_top_hold) else $error("pin capture while capture is top");
  property p_is_top; capture_is_top == (waveform_mode_field inside {4'h8, 4'ha, 4'hc, 4'he}); endproperty
  a_is_top: assert property (p_is_top) else $error("capture top decode wrong");
  property p_low_read;
    io_re && !io_we && io_addr == 8'h86 |=> io_rdata == $past(capture_value_reg[7:0])
      && high_byte_latch == $past(capture_value_reg[15:8]);
  endproperty
  a_low_read: assert property (p_low_read) else $error("low read or latch wrong");
  property p_reserved; io_re && (io_addr == 8'h16 || io_addr == 8'h6f) |=> (io_rdata & 8'hd8) == 8'h00; endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");
  property p_irq_off; !global_irq_enable |-> !(capture_irq || compare_b_irq || compare_a_irq || overflow_irq); endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without global enable");
  property p_mask_w;
    io_we && io_addr == 8'h6f |=> (!capture_irq || $past(io_wdata[5])) && (!compare_b_irq || $past(io_wdata[2]))
      && (!compare_a_irq || $past(io_wdata[1])) && (!overflow_irq || $past(io_wdata[0]));
  endproperty
  a_mask_w: assert property (p_mask_w) else $error("irq with mask bit clear");
  property p_sync_hold; sync_halt_mode && shared_prescaler_reset && !w23 |=> shared_prescaler_reset; endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("prescaler reset dropped in sync mode");
  property p_self_clr; !sync_halt_mode && !w23 |=> !shared_prescaler_reset && !async_prescaler_reset; endproperty
  a_self_clr: assert property (p_self_clr) else $error("prescaler reset did not clear");
endmodule : timer1_chk

bind timer1_capture_irq_prescaler timer1_chk timer1_chk_inst (
  .ref_clk, .nrst, .io_addr, .io_we, .io_re, .io_wdata, .io_rdata, .high_byte_latch, .counter_value,
  .capture_value_reg, .waveform_mode_field, .capture_is_top, .capture_input_pin, .capture_edge_select,
  .global_irq_enable, .capture_irq, .compare_b_irq, .compare_a_irq, .overflow_irq, .sync_halt_mode,
  .shared_prescaler_reset, .async_prescaler_reset
);

// [verif/timer1_capture_irq_prescaler_tb_top.sv]
`timescale 1ns/1ps
module timer1_capture_irq_prescaler_tb_top;
  logic              ref_clk = 1'b0, nrst = 1'b0, io_we = 1'b0, io_re = 1'b0, ext_latch_we = 1'b0;
  logic              capture_input_pin = 1'b0, capture_edge_select = 1'b0, global_irq_enable = 1'b0;
  logic [7:0]        io_addr = 8'h00;
  timer1_pkg::byte_t io_wdata = 8'h00, ext_latch_data = 8'h00, io_rdata, high_byte_latch;
  timer1_pkg::word_t counter_value = 16'h0000, compare_a_value = 16'h0001, compare_b_value = 16'h0002;
  timer1_pkg::word_t capture_value_reg;
  timer1_pkg::wgm_t  waveform_mode_field = 4'h0;
  logic [9:0]        pv = 10'h000;
  logic              timer_tick, counter_at_max, counter_at_top, counter_at_bottom, force_compare_a_strobe;
  logic              force_compare_b_strobe, capture_vector_ack, compare_b_vector_ack, compare_a_vector_ack;
  logic              overflow_vector_ack, capture_is_top, capture_irq, compare_b_irq, compare_a_irq;
  logic              overflow_irq, sync_halt_mode, shared_prescaler_reset, async_prescaler_reset;
  int                fails = 0, n_checks = 0, i;
  logic [7:0]        m_flags = 8'h00, m_mask;
  logic [15:0]       m_cap = 16'h0000;
  logic [3:0]        e4;
  logic [7:0]        ra [6] = '{8'h16, 8'h23, 8'h6f, 8'h86, 8'h87, 8'h40};
  logic [3:0]        om [5] = '{4'h0, 4'h4, 4'he, 4'h1, 4'h5};
  logic [9:0]        ov [5] = '{10'h100, 10'h100, 10'h080, 10'h040, 10'h100};
  int                fb [4] = '{0, 1, 2, 5};

  // all strobes live in one vector so one task fires any mix of them
  assign {timer_tick, counter_at_max, counter_at_top, counter_at_bottom, force_compare_a_strobe,
          force_compare_b_strobe, capture_vector_ack, compare_b_vector_ack, compare_a_vector_ack,
          overflow_vector_ack} = pv;

  timer1_capture_irq_prescaler timer1_capture_irq_prescaler_inst (
    .ref_clk, .nrst, .io_addr, .io_we, .io_re, .io_wdata, .io_rdata, .ext_latch_we, .ext_latch_data,
    .high_byte_latch, .timer_tick, .counter_value, .compare_a_value, .compare_b_value, .waveform_mode_field,
    .counter_at_max, .counter_at_top, .counter_at_bottom, .force_compare_a_strobe, .force_compare_b_strobe,
    .capture_is_top, .capture_value_reg, .capture_input_pin, .capture_edge_select, .global_irq_enable,
    .capture_vector_ack, .compare_b_vector_ack, .compare_a_vector_ack, .overflow_vector_ack, .capture_irq,
    .compare_b_irq, .compare_a_irq, .overflow_irq, .sync_halt_mode, .shared_prescaler_reset,
    .async_prescaler_reset
  );

  // 100 mhz clock
  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // overflow source by waveform mode
  function automatic logic ovf_hit(input logic [3:0] m, input logic [9:0] v);
    if (m inside {4'h0, 4'h4, 4'hc}) return v[8];
    if (m inside {4'h5, 4'h6, 4'h7, 4'he, 4'hf}) return v[7];
    return v[6];
  endfunction : ovf_hit

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    io_we   <= 1'b1;
    io_addr <= a;
    io_wdata <= d;
    @(posedge ref_clk);
    io_we <= 1'b0;
  endtask : wr

  // read data lands on the edge that takes io_re, so compare at the following low phase
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    io_re   <= 1'b1;
    io_addr <= a;
    @(posedge ref_clk);
    io_re <= 1'b0;
    @(negedge ref_clk);
    chk({8'h00, io_rdata}, {8'h00, e});
  endtask : rd

  task automatic pulse(input logic [9:0] v);
    @(posedge ref_clk);
    pv <= v;
    @(posedge ref_clk);
    pv <= 10'h000;
  endtask : pulse

  task automatic pin(input logic lvl);
    @(posedge ref_clk);
    capture_input_pin <= lvl;
    repeat (2) @(posedge ref_clk);
  endtask : pin

  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    fails++;
    finish_test();
  end

  initial begin
    void'($urandom(10));
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (ra[k]) rd(ra[k], 8'h00);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    $display("test reset done");
    wr(8'h23, 8'h81);
    repeat (4) @(posedge ref_clk);
    rd(8'h23, 8'h81);
    wr(8'h23, 8'h00);
    rd(8'h23, 8'h00);
    wr(8'h23, 8'h03);
    @(negedge ref_clk);
    chk({14'h0000, shared_prescaler_reset, async_prescaler_reset}, 16'h0003);
    @(negedge ref_clk);
    chk({14'h0000, shared_prescaler_reset, async_prescaler_reset}, 16'h0000);
    $display("test prescaler done");
    for (i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      counter_value       <= 16'($urandom);
      capture_edge_select <= 1'($urandom);
      @(posedge ref_clk);
      if (capture_edge_select == !capture_input_pin) begin
        m_cap      = counter_value;
        m_flags[5] = 1'b1;
      end
      pin(!capture_input_pin);
      rd(8'h86, m_cap[7:0]);
      rd(8'h87, m_cap[15:8]);
    end
    rd(8'h16, m_flags);
    @(posedge ref_clk);
    waveform_mode_field <= 4'hc;
    counter_value       <= ~m_cap;
    capture_edge_select <= !capture_input_pin;
    pin(!capture_input_pin);
    rd(8'h86, m_cap[7:0]);
    chk({15'h0000, capture_is_top}, 16'h0001);
    wr(8'h16, 8'h20);
    m_flags[5] = 1'b0;
    rd(8'h16, m_flags);
    pulse(10'h080);
    m_flags[5] = 1'b1;
    rd(8'h16, m_flags);
    @(posedge ref_clk);
    ext_latch_we   <= 1'b1;
    ext_latch_data <= 8'h5a;
    @(posedge ref_clk);
    ext_latch_we <= 1'b0;
    @(negedge ref_clk);
    chk({8'h00, high_byte_latch}, 16'h005a);
    m_cap = 16'($urandom);
    wr(8'h87, m_cap[15:8]);
    wr(8'h86, m_cap[7:0]);
    rd(8'h86, m_cap[7:0]);
    rd(8'h87, m_cap[15:8]);
    $display("test capture done");
    // compare: force strobes alone, then the arming tick, then the setting tick
    @(posedge ref_clk);
    waveform_mode_field <= 4'h0;
    compare_a_value     <= counter_value;
    compare_b_value     <= counter_value;
    pulse(10'h030);
    rd(8'h16, m_flags);
    pulse(10'h200);
    @(posedge ref_clk);
    compare_a_value <= ~counter_value;
    compare_b_value <= ~counter_value;
    rd(8'h16, m_flags);
    pulse(10'h200);
    m_flags[2:1] = 2'b11;
    rd(8'h16, m_flags);
    pulse(10'h100);
    m_flags[0] = 1'b1;
    rd(8'h16, m_flags);
    $display("test compare done");
    for (i = 0; i < 12; i++) begin
      m_mask = 8'($urandom);
      @(posedge ref_clk);
      global_irq_enable <= i[0];
      wr(8'h6f, m_mask);
      rd(8'h6f, m_mask & 8'h27);
      e4 = {4{i[0]}} & {m_mask[5], m_mask[2:0]} & {m_flags[5], m_flags[2:0]};
      chk(16'({capture_irq, compare_b_irq, compare_a_irq, overflow_irq}), 16'(e4));
    end
    for (i = 0; i < 4; i++) begin
      pulse(10'h001 << i);
      m_flags[fb[i]] = 1'b0;
      rd(8'h16, m_flags);
    end
    $display("test irq done");
    for (i = 0; i < 5; i++) begin
      @(posedge ref_clk);
      waveform_mode_field <= om[i];
      wr(8'h16, 8'hff);
      pulse(ov[i]);
      m_flags    = 8'h00;
      m_flags[0] = ovf_hit(om[i], ov[i]);
      m_flags[5] = (om[i] inside {4'h8, 4'ha, 4'hc, 4'he}) && ov[i][7];
      rd(8'h16, m_flags);
    end
    $display("test overflow done");
    finish_test();
  end
endmodule : timer1_capture_irq_prescaler_tb_top
